// >>> iosm_top.sv
// Routing switch matrix with inversion, force-high, prescaler and four-channel PWM.
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ns
`include "iosm_cfg.svh"

// Functional notes
// - Destination 6 acquisition trigger, 7 sequencer trigger.
// - Destinations 8 debouncer, 9 prescaler, 10-11 logic.
// - Destinations 13-16 trigger pulse generators 0-3.
// - Destinations 0-3 open-drain; 4 transmit unless debug.
// - One select bit per source, source 0 leftmost.
// - Inverter complements the routed line signal.
// - Force-high makes the line constant one.
// - Force-high with inversion gives constant zero.
// - Prescaler passes only every Nth input pulse.
// - Pulse generators 0, 1 return as sources 6, 7.
// - PWM period in ticks, chosen by interval selector.
// - Four channels hold percent duty per interval.
// - High time equals duty; 0 off, 100 on.
// - Sources 16,17,19,20,21: debouncer, prescaler, logic, generators.
// - Inputs at sources 0-3; PWM at 8,9,13,14.
// - Setting changes take effect without commit step.
module iosm_top
  import iosm_pkg::*;
#(
  parameter int PW = 24,
  parameter int DW = 7
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [9:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic [3:0] physIn,
  input wire logic serialRxPin,
  input wire logic serial1Tx,
  input wire logic [3:0] pulseGenOut,
  input wire logic expose,
  input wire logic readout,
  input wire logic seqPulseA,
  input wire logic seqPulseB,
  input wire logic seqActive,
  input wire logic debouncerOut,
  input wire logic logicOut,
  input wire logic lensRx,
  input wire logic triggerFeedback,
  input wire logic serial2Tx,
  input wire logic [3:0] interval_selector,
  output logic [3:0] openDrainOe,
  output logic serialTxPin,
  output logic serial1_rx_feed,
  output logic acqTrigger,
  output logic interval_engine_trigger_in,
  output logic debouncerIn,
  output logic logicOperandA,
  output logic logicOperandB,
  output logic lensTx,
  output logic [3:0] pulseGenTrigger,
  output logic serial2_rx_feed,
  output logic [3:0] pwmOut
);

  // Software state of the matrix.
  iosm_srcvec_t destSel [`IOSM_NDST];
  iosm_dstvec_t invMask;
  iosm_dstvec_t frcMask;
  logic debugMode;
  iosm_prescale_t preFactor;
  // Software state of the PWM, one entry per sequencer interval.
  logic [PW-1:0] pwm_period_ticks [`IOSM_NINT];
  logic [DW-1:0] pwm_duty_percent [`IOSM_NINT][`IOSM_NPWM];
  // Matrix signals.
  iosm_srcvec_t srcMsb;
  iosm_dstvec_t next_dest;
  iosm_dstvec_t destQ;
  logic presOut;
  logic presPrev;
  logic presGate;
  iosm_prescale_t presCnt;
  logic presRise;
  logic presPass;
  // PWM signals.
  logic [PW-1:0] pwmCnt;
  logic [PW-1:0] curPeriod;
  logic [DW-1:0] curDuty [`IOSM_NPWM];
  logic [3:0] pwmQ;
  logic pwmWrap;
  logic [31:0] next_rdata;

  // Routes one destination: any selected source drives it, then force and inversion apply.
  function automatic logic route(input iosm_srcvec_t sel, input iosm_srcvec_t src,
                                 input logic inv, input logic frc);
    logic hit;
    hit = |(sel & src);
    if (frc) begin
      return ~inv;
    end
    return hit ^ inv;
  endfunction

  // Tells whether an address falls into a word-indexed table.
  function automatic logic inRange(input logic [9:0] a, input logic [9:0] lo,
                                   input logic [9:0] hi);
    return (a >= lo) && (a < hi) && (a[1:0] == 2'b00);
  endfunction

  // Source vector, source 0 in the leftmost bit so it lines up with the select word.
  assign srcMsb = {physIn[0], physIn[1], physIn[2], physIn[3],
                   serialRxPin, serial1Tx,
                   pulseGenOut[0], pulseGenOut[1],
                   pwmQ[0], pwmQ[1], expose, readout, seqPulseA, pwmQ[2], pwmQ[3],
                   seqActive, debouncerOut, presOut, seqPulseB, logicOut,
                   pulseGenOut[2], pulseGenOut[3],
                   lensRx, triggerFeedback, serial2Tx};

  // One routing cell per destination.
  genvar gd;
  generate
    for (gd = 0; gd < `IOSM_NDST; gd++) begin : g_dest
      assign next_dest[gd] = route(destSel[gd], srcMsb, invMask[gd], frcMask[gd]);
    end
  endgenerate

  // Register writes land on the next edge and act at once, with no commit step.
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < `IOSM_NDST; i++) begin
        destSel[i] <= '0;
      end
      invMask <= '0;
      frcMask <= '0;
      debugMode <= 1'b0;
      preFactor <= `IOSM_PRE_RST;
    end else if (regWr) begin
      if (regAddr == `IOSM_ADDR_INV) begin
        invMask <= regWdata[17:0];
      end else if (regAddr == `IOSM_ADDR_FRC) begin
        frcMask <= regWdata[17:0];
      end else if (regAddr == `IOSM_ADDR_CTRL) begin
        debugMode <= regWdata[`IOSM_CTRL_DEBUG];
        preFactor <= regWdata[`IOSM_CTRL_PRE_LSB +: 8];
      end else if (inRange(regAddr, `IOSM_ADDR_SEL, `IOSM_ADDR_SEL_END)) begin
        destSel[regAddr[6:2]] <= regWdata[24:0];
      end
    end
  end

  // PWM table writes; the running period keeps its latched copy until it ends.
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < `IOSM_NINT; i++) begin
        pwm_period_ticks[i] <= '0;
        for (int c = 0; c < `IOSM_NPWM; c++) begin
          pwm_duty_percent[i][c] <= '0;
        end
      end
    end else if (regWr) begin
      if (inRange(regAddr, `IOSM_ADDR_PER, `IOSM_ADDR_DUTY)) begin
        pwm_period_ticks[regAddr[5:2]] <= regWdata[PW-1:0];
      end else if (inRange(regAddr, `IOSM_ADDR_DUTY, `IOSM_ADDR_DUTY_END)) begin
        for (int c = 0; c < `IOSM_NPWM; c++) begin
          pwm_duty_percent[regAddr[5:2]][c] <= regWdata[8*c +: DW];
        end
      end
    end
  end

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    next_rdata = '0;
    if (regAddr == `IOSM_ADDR_INV) begin
      next_rdata[17:0] = invMask;
    end else if (regAddr == `IOSM_ADDR_FRC) begin
      next_rdata[17:0] = frcMask;
    end else if (regAddr == `IOSM_ADDR_CTRL) begin
      next_rdata[`IOSM_CTRL_DEBUG] = debugMode;
      next_rdata[`IOSM_CTRL_PRE_LSB +: 8] = preFactor;
    end else if (regAddr == `IOSM_ADDR_SRCST) begin
      next_rdata[24:0] = srcMsb;
    end else if (regAddr == `IOSM_ADDR_DSTST) begin
      next_rdata[17:0] = destQ;
    end else if (inRange(regAddr, `IOSM_ADDR_SEL, `IOSM_ADDR_SEL_END)) begin
      next_rdata[24:0] = destSel[regAddr[6:2]];
    end else if (inRange(regAddr, `IOSM_ADDR_PER, `IOSM_ADDR_DUTY)) begin
      next_rdata[PW-1:0] = pwm_period_ticks[regAddr[5:2]];
    end else if (inRange(regAddr, `IOSM_ADDR_DUTY, `IOSM_ADDR_DUTY_END)) begin
      for (int c = 0; c < `IOSM_NPWM; c++) begin
        next_rdata[8*c +: DW] = pwm_duty_percent[regAddr[5:2]][c];
      end
    end
  end

  // Read data stand for one cycle after the strobe and are zero otherwise.
  always_ff @(posedge clock) begin
    if (srst) begin
      regRdata <= '0;
    end else begin
      regRdata <= regRd ? next_rdata : 32'h00000000;
    end
  end

  // All destinations are registered once, one clock after their sources.
  always_ff @(posedge clock) begin
    if (srst) begin
      destQ <= '0;
      openDrainOe <= 4'h0;
      serialTxPin <= 1'b1;
    end else begin
      destQ <= next_dest;
      openDrainOe <= ~next_dest[3:0];
      serialTxPin <= debugMode ? 1'b1 : next_dest[`IOSM_D_TXD];
    end
  end

  // Destination lines onto the module ports.
  assign acqTrigger = destQ[`IOSM_D_TRIG];
  assign interval_engine_trigger_in = destQ[`IOSM_D_SEQ];
  assign debouncerIn = destQ[`IOSM_D_DEB];
  assign logicOperandA = destQ[`IOSM_D_LGA];
  assign logicOperandB = destQ[`IOSM_D_LGB];
  assign lensTx = destQ[`IOSM_D_LENS];
  assign serial1_rx_feed = destQ[`IOSM_D_RX1];
  assign serial2_rx_feed = destQ[`IOSM_D_RX2];
  assign pulseGenTrigger = destQ[`IOSM_D_PG0 +: 4];

  // A pulse passes when the rising-edge count reaches the factor; 0 and 1 pass all.
  assign presRise = destQ[`IOSM_D_PRE] & ~presPrev;
  assign presPass = (preFactor <= 8'h01) || (presCnt >= preFactor - 8'h01);

  // Prescaler on destination 9, output fed back as source 17.
  always_ff @(posedge clock) begin
    if (srst) begin
      presPrev <= 1'b0;
      presGate <= 1'b0;
      presCnt <= '0;
      presOut <= 1'b0;
    end else begin
      presPrev <= destQ[`IOSM_D_PRE];
      if (presRise) begin
        presGate <= presPass;
        presCnt <= presPass ? 8'h00 : presCnt + 8'h01;
      end
      presOut <= destQ[`IOSM_D_PRE] & (presRise ? presPass : presGate);
    end
  end

  // The period ends on its last tick; a zero period reloads every clock.
  assign pwmWrap = (curPeriod == '0) || (pwmCnt == curPeriod - 1'b1);

  // Period counter; period and duties are latched only at a period boundary.
  always_ff @(posedge clock) begin
    if (srst) begin
      pwmCnt <= '0;
      curPeriod <= '0;
      for (int c = 0; c < `IOSM_NPWM; c++) begin
        curDuty[c] <= '0;
      end
    end else if (pwmWrap) begin
      pwmCnt <= '0;
      curPeriod <= pwm_period_ticks[interval_selector];
      for (int c = 0; c < `IOSM_NPWM; c++) begin
        curDuty[c] <= pwm_duty_percent[interval_selector][c];
      end
    end else begin
      pwmCnt <= pwmCnt + 1'b1;
    end
  end

  // Each channel is high while count times 100 is below period times duty.
  genvar gc;
  generate
    for (gc = 0; gc < `IOSM_NPWM; gc++) begin : g_pwm
      logic [PW+DW-1:0] lhs;
      logic [PW+DW-1:0] rhs;
      assign lhs = (PW+DW)'(pwmCnt) * (PW+DW)'(`IOSM_PCT_FULL);
      assign rhs = (PW+DW)'(curPeriod) * (PW+DW)'(curDuty[gc]);
      always_ff @(posedge clock) begin
        if (srst) begin
          pwmQ[gc] <= 1'b0;
        end else begin
          pwmQ[gc] <= lhs < rhs;
        end
      end
    end
  endgenerate

  assign pwmOut = pwmQ;

  // Checks on the routing cells.
  sequence s_quiet;
    !srst && !$past(srst);
  endsequence

  property p_force;
    @(posedge clock) disable iff (srst) s_quiet |-> ((($past(frcMask & ~invMask)) & ~destQ) == '0);
  endproperty
  a_force: assert property (p_force) else $error("forced line not high");

  property p_forceInv;
    @(posedge clock) disable iff (srst) s_quiet |-> ((($past(frcMask & invMask)) & destQ) == '0);
  endproperty
  a_forceInv: assert property (p_forceInv) else $error("forced inverted line not low");

  property p_invert;
    @(posedge clock) disable iff (srst)
      (destSel[`IOSM_D_TRIG] == 25'h1000000 && invMask[`IOSM_D_TRIG] && !frcMask[`IOSM_D_TRIG])
      |=> (acqTrigger == !$past(physIn[0]));
  endproperty
  a_invert: assert property (p_invert) else $error("inverted trigger wrong");

  property p_trigRoute;
    @(posedge clock) disable iff (srst)
      (destSel[`IOSM_D_SEQ] == 25'h0040000 && invMask == '0 && frcMask == '0)
      |=> (interval_engine_trigger_in == $past(pulseGenOut[0]));
  endproperty
  a_trigRoute: assert property (p_trigRoute) else $error("sequencer trigger route wrong");

  sequence s_selWrite;
    regWr && regAddr == `IOSM_ADDR_SEL && invMask[0] == 1'b0 && frcMask[0] == 1'b0;
  endsequence

  property p_apply;
    @(posedge clock) disable iff (srst)
      s_selWrite ##1 (!regWr && invMask[0] == 1'b0 && frcMask[0] == 1'b0)
      |=> (openDrainOe[0] == !(|($past(destSel[0]) & $past(srcMsb))));
  endproperty
  a_apply: assert property (p_apply) else $error("select write not applied in time");

  // Checks on the PWM, the prescaler and the debug transmit pin.
  property p_latchAtWrap;
    @(posedge clock) disable iff (srst) !$past(srst) && $changed(curPeriod) |-> $past(pwmWrap);
  endproperty
  a_latchAtWrap: assert property (p_latchAtWrap) else $error("period changed mid period");

  property p_cntBound;
    @(posedge clock) disable iff (srst) (curPeriod != '0) |-> (pwmCnt < curPeriod);
  endproperty
  a_cntBound: assert property (p_cntBound) else $error("count beyond period");

  property p_dutyZero;
    @(posedge clock) disable iff (srst) (curDuty[0] == '0) ##1 (curDuty[0] == '0) |-> !pwmQ[0];
  endproperty
  a_dutyZero: assert property (p_dutyZero) else $error("zero duty not off");

  property p_dutyFull;
    @(posedge clock) disable iff (srst)
      (curDuty[1] == `IOSM_PCT_FULL && curPeriod != '0) ##1 (curDuty[1] == `IOSM_PCT_FULL)
      |-> pwmQ[1];
  endproperty
  a_dutyFull: assert property (p_dutyFull) else $error("full duty not on");

  property p_prescale;
    @(posedge clock) disable iff (srst) $rose(presOut) |-> $past(destQ[`IOSM_D_PRE]);
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescaler output without input");

  property p_debug;
    @(posedge clock) disable iff (srst) $past(debugMode) && !$past(srst) |-> serialTxPin;
  endproperty
  a_debug: assert property (p_debug) else $error("transmit pin driven in debug");

endmodule

// >>> iosm_cfg.svh
// Register offsets, field positions, reset values and line indices of the switch matrix.
`ifndef IOSM_CFG_SVH
`define IOSM_CFG_SVH
`define IOSM_NSRC 25
`define IOSM_NDST 18
`define IOSM_NINT 16
`define IOSM_NPWM 4
`define IOSM_ADDR_SEL 10'h000
`define IOSM_ADDR_SEL_END 10'h048
`define IOSM_ADDR_INV 10'h080
`define IOSM_ADDR_FRC 10'h084
`define IOSM_ADDR_CTRL 10'h088
`define IOSM_ADDR_SRCST 10'h08c
`define IOSM_ADDR_DSTST 10'h090
`define IOSM_ADDR_PER 10'h100
`define IOSM_ADDR_DUTY 10'h140
`define IOSM_ADDR_DUTY_END 10'h180
`define IOSM_CTRL_DEBUG 0
`define IOSM_CTRL_PRE_LSB 8
`define IOSM_PRE_RST 8'h01
`define IOSM_PCT_FULL 7'h64
`define IOSM_TICK_NS 15
`define IOSM_CLK_NS 20
`define IOSM_D_TXD 4
`define IOSM_D_RX1 5
`define IOSM_D_TRIG 6
`define IOSM_D_SEQ 7
`define IOSM_D_DEB 8
`define IOSM_D_PRE 9
`define IOSM_D_LGA 10
`define IOSM_D_LGB 11
`define IOSM_D_LENS 12
`define IOSM_D_PG0 13
`define IOSM_D_RX2 17
`endif

// >>> iosm_pkg.sv
// Types shared by the switch matrix and its PWM.
package iosm_pkg;
  typedef logic [24:0] iosm_srcvec_t;
  typedef logic [17:0] iosm_dstvec_t;
  typedef logic [7:0] iosm_prescale_t;
endpackage

// >>> iosm_far_side.sv
// Far-side model: trigger sources, LED pads and external equipment around the matrix.
`timescale 1ns/1ns
module iosm_far_side (
  input wire logic [24:0] srcVec,
  input wire logic [3:0] openDrainOe,
  output logic [3:0] physIn,
  output logic serialRxPin,
  output logic serial1Tx,
  output logic [3:0] pulseGenOut,
  output logic expose,
  output logic readout,
  output logic seqPulseA,
  output logic seqPulseB,
  output logic seqActive,
  output logic debouncerOut,
  output logic logicOut,
  output logic lensRx,
  output logic triggerFeedback,
  output logic serial2Tx,
  output logic [3:0] pad
);
  // Each commanded source bit except 8, 9, 13, 14 and 17 drives the pin that the matrix sees at that index.
  assign physIn = srcVec[3:0];
  assign serialRxPin = srcVec[4];
  assign serial1Tx = srcVec[5];
  assign pulseGenOut = {srcVec[21], srcVec[20], srcVec[7], srcVec[6]};
  assign expose = srcVec[10];
  assign readout = srcVec[11];
  assign seqPulseA = srcVec[12];
  assign seqActive = srcVec[15];
  assign debouncerOut = srcVec[16];
  assign seqPulseB = srcVec[18];
  assign logicOut = srcVec[19];
  assign lensRx = srcVec[22];
  assign triggerFeedback = srcVec[23];
  assign serial2Tx = srcVec[24];
  // Open-drain pads sit on pull-ups, so a pad is low only while the camera sinks it.
  assign pad = ~openDrainOe;
endmodule

// >>> io_switch_matrix_pwm_bench.sv
// Self-checking bench for the switch matrix and its PWM.
`timescale 1ns/1ns
`include "iosm_cfg.svh"
module io_switch_matrix_pwm_bench;
  import iosm_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [9:0] regAddr = 10'h000;
  logic [31:0] regWdata = 32'h0;
  logic [31:0] regRdata;
  logic [24:0] srcVec = 25'h0;
  logic [3:0] interval_selector = 4'h0;
  logic [3:0] physIn, pulseGenOut, pad, openDrainOe, pulseGenTrigger, pwmOut;
  logic serialRxPin, serial1Tx, expose, readout, seqPulseA, seqPulseB, seqActive;
  logic debouncerOut, logicOut, lensRx, triggerFeedback, serial2Tx, serialTxPin;
  logic serial1_rx_feed, acqTrigger, interval_engine_trigger_in, debouncerIn;
  logic logicOperandA, logicOperandB, lensTx, serial2_rx_feed;
  logic prevAcq = 1'b0;
  logic [31:0] edgeCnt = 32'h0;
  logic [31:0] base;
  logic [17:0] obs;
  int err_total = 0;
  int samples_checked = 0;

  // Destination lines as seen outside; line 9 only feeds the prescaler.
  assign obs = {serial2_rx_feed, pulseGenTrigger, lensTx, logicOperandB, logicOperandA, 1'b0,
    debouncerIn, interval_engine_trigger_in, acqTrigger, serial1_rx_feed, serialTxPin, pad};

  iosm_top u_dut (.clock, .srst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .physIn,
    .serialRxPin, .serial1Tx, .pulseGenOut, .expose, .readout, .seqPulseA, .seqPulseB,
    .seqActive, .debouncerOut, .logicOut, .lensRx, .triggerFeedback, .serial2Tx,
    .interval_selector, .openDrainOe, .serialTxPin, .serial1_rx_feed, .acqTrigger,
    .interval_engine_trigger_in, .debouncerIn, .logicOperandA, .logicOperandB, .lensTx,
    .pulseGenTrigger, .serial2_rx_feed, .pwmOut);

  iosm_far_side u_far (.srcVec, .openDrainOe, .physIn, .serialRxPin, .serial1Tx, .pulseGenOut,
    .expose, .readout, .seqPulseA, .seqPulseB, .seqActive, .debouncerOut, .logicOut, .lensRx,
    .triggerFeedback, .serial2Tx, .pad);

  // Clock of 20 ns period.
  always #10 clock = ~clock;

  // Counts rising edges of the acquisition trigger.
  always @(posedge clock) begin
    prevAcq <= acqTrigger;
    if (acqTrigger === 1'b1 && prevAcq === 1'b0) edgeCnt <= edgeCnt + 32'h1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Aligns to an edge, then a one-cycle write strobe and one idle cycle.
  task automatic wr(input logic [9:0] a, input logic [31:0] v);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge clock);
    regWr <= 1'b0;
    @(posedge clock);
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    #1 chk(regRdata, e);
    @(posedge clock);
  endtask

  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask

  // High cycles per channel over 100 clocks, one byte of the expectation per channel.
  task automatic meas(input logic [31:0] e);
    logic [7:0] hi [4];
    for (int c = 0; c < 4; c++) hi[c] = 8'h0;
    repeat (100) begin
      @(posedge clock);
      #1;
      for (int c = 0; c < 4; c++) hi[c] = hi[c] + 8'(pwmOut[c]);
    end
    for (int c = 0; c < 4; c++) chk({24'h0, hi[c]}, {24'h0, e[8*c +: 8]});
  endtask

  task complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    #400000;
    err_total++;
    $display("watchdog expired");
    complete_run;
  end

  initial begin
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rd(`IOSM_ADDR_CTRL, 32'h100);
    rd(10'h3fc, 32'h0);
    srcVec <= 25'h1;
    settle;
    chk({28'h0, pad}, 32'h0);
    $display("test reset done");
    for (int d = 0; d < 18; d++) begin
      wr(`IOSM_ADDR_SEL + 10'(4 * d), 32'h1000000);
      settle;
      chk({14'h0, obs}, (32'h1 << d) & 32'h3fdff);
      rd(`IOSM_ADDR_DSTST, 32'h1 << d);
      wr(`IOSM_ADDR_SEL + 10'(4 * d), 32'h0);
    end
    $display("test destinations done");
    for (int s = 0; s < 25; s++) begin
      if (s inside {8, 9, 13, 14, 17}) continue;
      srcVec <= 25'h1 << s;
      wr(`IOSM_ADDR_SEL + 10'(4 * `IOSM_D_TRIG), 32'h1000000 >> s);
      settle;
      chk({31'h0, acqTrigger}, 32'h1);
      rd(`IOSM_ADDR_SRCST, 32'h1000000 >> s);
    end
    $display("test sources done");
    srcVec <= 25'h40;
    wr(`IOSM_ADDR_SEL + 10'(4 * `IOSM_D_SEQ), 32'h40000);
    settle;
    chk({31'h0, interval_engine_trigger_in}, 32'h1);
    wr(`IOSM_ADDR_SEL + 10'(4 * `IOSM_D_SEQ), 32'h0);
    wr(`IOSM_ADDR_SEL + 10'(4 * `IOSM_D_TRIG), 32'h1000000);
    for (int i = 0; i < 8; i++) begin
      wr(`IOSM_ADDR_INV, 32'((i >> 1) & 1) << 6);
      wr(`IOSM_ADDR_FRC, 32'(i >> 2) << 6);
      srcVec <= 25'(i & 1);
      settle;
      chk({31'h0, acqTrigger}, (i >= 4) ? {31'h0, ~i[1]} : {31'h0, i[0] ^ i[1]});
    end
    wr(`IOSM_ADDR_INV, 32'h0);
    wr(`IOSM_ADDR_FRC, 32'h0);
    $display("test invert and force done");
    srcVec <= 25'h0;
    wr(`IOSM_ADDR_SEL + 10'(4 * `IOSM_D_PRE), 32'h1000000);
    wr(`IOSM_ADDR_SEL + 10'(4 * `IOSM_D_TRIG), 32'h80);
    for (int f = 0; f < 4; f++) begin
      wr(`IOSM_ADDR_CTRL, 32'(f) << 8);
      settle;
      base = edgeCnt;
      @(posedge clock);
      repeat (6) begin
        srcVec <= 25'h1;
        repeat (2) @(posedge clock);
        srcVec <= 25'h0;
        repeat (2) @(posedge clock);
      end
      settle;
      chk(edgeCnt - base, 32'(6 / ((f == 0) ? 1 : f)));
    end
    wr(`IOSM_ADDR_CTRL, 32'h101);
    settle;
    chk({31'h0, serialTxPin}, 32'h1);
    $display("test prescaler and debug done");
    wr(`IOSM_ADDR_PER, 32'd10);
    wr(`IOSM_ADDR_DUTY, 32'h001e6432);
    rd(`IOSM_ADDR_PER, 32'd10);
    repeat (30) @(posedge clock);
    meas(32'h001e6432);
    wr(`IOSM_ADDR_PER + 10'h4, 32'd20);
    wr(`IOSM_ADDR_DUTY + 10'h4, 32'h19);
    rd(`IOSM_ADDR_DUTY + 10'h4, 32'h19);
    interval_selector <= 4'h1;
    repeat (50) @(posedge clock);
    meas(32'h19);
    $display("test pwm done");
    complete_run;
  end
endmodule
